/* File: sysconf_pkg.sv */
// Shared constants, field layouts and types of the system configuration block
`default_nettype none
package sysconf_pkg;
  localparam int unsigned CORE_CLK_MHZ = 25;
  // Crystal silence that counts as a dead oscillator
  localparam int unsigned OSC_SILENCE_NS = 1000;
  localparam int unsigned OSC_SILENCE_CYCLES = (OSC_SILENCE_NS * CORE_CLK_MHZ + 999) / 1000;
  // One half clock period of the bus, modelled as one core cycle
  localparam int unsigned HALF_CLOCK_PERIOD_CYCLES = 1;
  localparam int unsigned SYNC_STAGES = 2;

  localparam int unsigned ADDR_W = 20;
  localparam logic [15:0] SYSCFG_INDEX = 16'hff12;
  localparam logic [15:0] STATUS_INDEX = 16'hff13;
  localparam logic [15:0] SYSCFG_RESET = 16'h0000;

  // Fields filled from straps after reset
  localparam int unsigned WRITE_CFG_POS = 7;
  localparam int unsigned BYTE_HIGH_DIS_POS = 9;
  localparam int unsigned INT_MEM_EN_POS = 10;
  localparam logic [15:0] STRAP_MASK = 16'h0680;
  localparam logic [1:0] STRAP_LOAD_COUNT = 2'h2;

  typedef struct packed {
    logic [2:0] stack_size_select;
    logic       internal_memory_segment_select;
    logic       segmentation_disable;
    logic       internal_memory_enable;
    logic       byte_high_disable;
    logic       clock_output_enable;
    logic       write_strobe_config;
    logic       chip_select_timing_config;
    logic       powerdown_config;
    logic       osc_watchdog_disable;
    logic       bidir_reset_pin_enable;
    logic       internal_peripheral_enable;
    logic       visible_mode;
    logic       peripheral_share_mode;
  } system_configuration_type;

  typedef struct packed {
    logic external_access_pin;
    logic bus_is_8bit;
    logic latched_write_config;
  } reset_strap_type;

  typedef struct packed {
    logic cpu_clock_from_pll;
    logic reset_pin_level;
    logic osc_clock_fail;
    logic powerdown_active;
  } block_status_type;

  function automatic logic [ADDR_W-1:0] byte_address(input logic [15:0] index);
    byte_address = {2'h0, index, 2'h0};
  endfunction

  // Stack size in words: 32 doubling per code, capped at 1024
  function automatic logic [10:0] stack_words(input logic [2:0] code);
    logic [2:0] capped;
    capped = (code > 3'h5) ? 3'h5 : code;
    stack_words = 11'h020 << capped;
  endfunction
endpackage
`default_nettype wire

/* File: osc_watchdog.sv */
// Crystal activity monitor that flags a silent oscillator
`timescale 1ns/10ps
`default_nettype none
module osc_watchdog #(
  parameter int unsigned SILENCE_CYCLES = sysconf_pkg::OSC_SILENCE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic crystal_input,
  input  wire logic watch_enable,
  output logic      osc_fail
);
  import sysconf_pkg::*;
  localparam int unsigned CW = $clog2(SILENCE_CYCLES + 1);

  if (SILENCE_CYCLES < 2) begin : g_bad_silence
    $error("osc_watchdog: silence count too small");
  end

  logic [1:0]    xtal_sync;
  logic          xtal_prev;
  logic [CW-1:0] silent_count;
  wire           xtal_edge = xtal_sync[1] ^ xtal_prev;
  wire           silence_done = (silent_count == CW'(SILENCE_CYCLES - 1));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_sync <= 2'h0;
      xtal_prev <= 1'b0;
    end else begin
      xtal_sync <= {xtal_sync[0], crystal_input};
      xtal_prev <= xtal_sync[1];
    end
  end

  // Sticky until monitoring is switched off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      silent_count <= '0;
      osc_fail     <= 1'b0;
    end else if (!watch_enable || xtal_edge) begin
      silent_count <= '0;
      osc_fail     <= osc_fail && watch_enable;
    end else if (silence_done) begin
      osc_fail <= 1'b1;
    end else begin
      silent_count <= silent_count + CW'(1);
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_silence_fail: assert property (watch_enable && !xtal_edge && silence_done |=> osc_fail)
    else $error("silent crystal not flagged");
endmodule
`default_nettype wire

/* File: chip_select_stage.sv */
// Chip select output stage, latched or unlatched against address latch enable
`timescale 1ns/10ps
`default_nettype none
module chip_select_stage #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             address_latch_enable,
  input  wire logic [WIDTH-1:0] cs_next,
  input  wire logic             unlatched_mode,
  output logic [WIDTH-1:0]      chip_select_outputs
);
  import sysconf_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("chip_select_stage: WIDTH must be at least 1");
  end
  if (HALF_CLOCK_PERIOD_CYCLES != 1) begin : g_bad_delay
    $error("chip_select_stage: one cycle delay only");
  end

  logic             ale_prev;
  logic             pending;
  logic [WIDTH-1:0] held;
  wire              ale_rise = address_latch_enable && !ale_prev;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ale_prev            <= 1'b0;
      pending             <= 1'b0;
      held                <= '0;
      chip_select_outputs <= '0;
    end else begin
      ale_prev <= address_latch_enable;
      pending  <= ale_rise && !unlatched_mode;
      if (ale_rise) held <= cs_next;
      if (ale_rise && unlatched_mode) begin
        chip_select_outputs <= cs_next;
      end else if (pending) begin
        chip_select_outputs <= held;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_cs_unlatched: assert property (ale_rise && unlatched_mode
    |=> chip_select_outputs == $past(cs_next))
    else $error("unlatched chip select not updated at latch enable");
  chk_cs_latched: assert property (ale_rise && !unlatched_mode
    |=> ##1 chip_select_outputs == $past(cs_next, 2))
    else $error("latched chip select not updated one half period later");
endmodule
`default_nettype wire

/* File: system_config_register.sv */
// System configuration register with APB access and the chip-wide controls it steers
`timescale 1ns/10ps
`default_nettype none
module system_config_register #(
  parameter int unsigned CS_WIDTH      = 5,
  parameter int unsigned FAST_INT_W    = 8,
  parameter int unsigned CLK_DIV_W     = 4
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [sysconf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  input  wire sysconf_pkg::reset_strap_type  reset_straps,
  input  wire logic                          hold_mode,
  input  wire logic                          internal_reset_active,
  input  wire logic                          reset_input_pin_in,
  output logic                               reset_input_pin_out,
  output logic                               reset_input_pin_oe,
  input  wire logic                          crystal_input,
  input  wire logic                          pll_bypassed,
  input  wire logic                          powerdown_instruction,
  input  wire logic                          nmi_pin,
  input  wire logic [FAST_INT_W-1:0]         fast_external_interrupt_pin,
  input  wire logic [FAST_INT_W-1:0]         fast_interrupt_enable,
  input  wire logic                          address_latch_enable,
  input  wire logic [CS_WIDTH-1:0]           chip_select_next,
  input  wire logic [CLK_DIV_W-1:0]          clock_output_divider,
  output logic [CS_WIDTH-1:0]                chip_select_outputs,
  output logic                               xbus_external_block,
  output logic                               xram_hold_access,
  output logic                               xbus_visible,
  output logic                               xbus_enable,
  output logic                               cpu_clock_from_pll,
  output logic                               pll_power_off,
  output logic                               powerdown_active,
  output logic                               split_write_strobes,
  output logic                               clock_output_pin,
  output logic                               clock_output_pin_oe,
  output logic                               byte_high_enable_pin_enable,
  output logic                               flash_area_external,
  output logic                               save_code_segment,
  output logic [7:0]                         internal_memory_segment,
  output logic [10:0]                        stack_size_words
);
  import sysconf_pkg::*;

  if (FAST_INT_W < 1 || CS_WIDTH < 1 || CLK_DIV_W < 1) begin : g_bad_width
    $error("bad width parameter");
  end

  system_configuration_type cfg;
  block_status_type         status;
  logic                     strap_pending;
  logic [1:0]               strap_count;
  reset_strap_type          strap_sync [SYNC_STAGES];
  logic [1:0]               nmi_sync;
  logic [1:0]               rst_pin_sync;
  logic [FAST_INT_W-1:0]    fast_sync [SYNC_STAGES];
  logic [CLK_DIV_W-1:0]     clk_div_count;
  logic                     osc_fail;

  // Bus decode
  wire logic [ADDR_W-1:0] syscfg_addr = byte_address(SYSCFG_INDEX);
  wire logic [ADDR_W-1:0] status_addr = byte_address(STATUS_INDEX);
  wire logic hit_cfg = (paddr == syscfg_addr);
  wire logic hit_status = (paddr == status_addr);
  wire logic setup_phase = psel && !penable;
  wire logic access_done = psel && penable && pready;
  wire logic cfg_write = access_done && pwrite && hit_cfg && !pslverr;
  wire logic [15:0] read_word;
  wire logic addr_error;

  assign read_word = hit_cfg ? cfg : (hit_status ? {12'h000, status} : 16'h0000);
  assign addr_error = !(hit_cfg || hit_status) || (pwrite && hit_status);

  // Pin level and power-down conditions
  wire logic [FAST_INT_W-1:0] fast_active = fast_sync[1] & fast_interrupt_enable;
  wire logic external_reset = !rst_pin_sync[1];
  wire logic pd_entry_ok = cfg.powerdown_config ? !(|fast_active) : !nmi_sync[1];
  wire logic pd_exit = external_reset || (cfg.powerdown_config && (|fast_active));
  wire logic osc_watch = !cfg.osc_watchdog_disable && pll_bypassed;
  wire logic clk_div_wrap = (clk_div_count == clock_output_divider);

  assign status = '{cpu_clock_from_pll: cpu_clock_from_pll,
                    reset_pin_level:    rst_pin_sync[1],
                    osc_clock_fail:     osc_fail,
                    powerdown_active:   powerdown_active};

  // APB answer, ready one cycle after setup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && addr_error;
      prdata  <= (setup_phase && !pwrite) ? {16'h0000, read_word} : 32'h0000_0000;
    end
  end

  // Strap capture after reset release, through synchronisers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync[0] <= '0;
      strap_sync[1] <= '0;
      strap_count   <= 2'h0;
      strap_pending <= 1'b1;
    end else begin
      strap_sync[0] <= reset_straps;
      strap_sync[1] <= strap_sync[0];
      if (strap_pending) strap_count <= strap_count + 2'h1;
      if (strap_count == STRAP_LOAD_COUNT) strap_pending <= 1'b0;
    end
  end

  // Configuration register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= SYSCFG_RESET;
    end else if (strap_pending && strap_count == STRAP_LOAD_COUNT) begin
      cfg.write_strobe_config    <= !strap_sync[1].latched_write_config;
      cfg.byte_high_disable      <= strap_sync[1].bus_is_8bit;
      cfg.internal_memory_enable <= strap_sync[1].external_access_pin;
    end else if (cfg_write) begin
      cfg <= pwdata[15:0];
    end
  end

  // Pin synchronisers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_sync     <= 2'h3;
      rst_pin_sync <= 2'h3;
      fast_sync[0] <= '0;
      fast_sync[1] <= '0;
    end else begin
      nmi_sync     <= {nmi_sync[0], nmi_pin};
      rst_pin_sync <= {rst_pin_sync[0], reset_input_pin_in};
      fast_sync[0] <= fast_external_interrupt_pin;
      fast_sync[1] <= fast_sync[0];
    end
  end

  // Bus and pin controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      xbus_external_block <= 1'b1;
      xram_hold_access    <= 1'b0;
      xbus_visible        <= 1'b0;
      xbus_enable         <= 1'b0;
      reset_input_pin_out <= 1'b0;
      reset_input_pin_oe  <= 1'b0;
    end else begin
      xbus_external_block <= !cfg.peripheral_share_mode;
      xram_hold_access    <= cfg.peripheral_share_mode && hold_mode;
      xbus_visible        <= cfg.visible_mode && cfg.internal_peripheral_enable;
      xbus_enable         <= cfg.internal_peripheral_enable;
      reset_input_pin_out <= 1'b0;
      reset_input_pin_oe  <= cfg.bidir_reset_pin_enable && internal_reset_active;
    end
  end

  // Clock source, power-down and clock output
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clock_from_pll  <= 1'b0;
      pll_power_off       <= 1'b0;
      powerdown_active    <= 1'b0;
      clk_div_count       <= '0;
      clock_output_pin    <= 1'b0;
      clock_output_pin_oe <= 1'b0;
    end else begin
      cpu_clock_from_pll <= osc_watch ? osc_fail : !pll_bypassed;
      pll_power_off      <= cfg.osc_watchdog_disable && pll_bypassed;
      if (powerdown_active && pd_exit) begin
        powerdown_active <= 1'b0;
      end else if (powerdown_instruction && pd_entry_ok) begin
        powerdown_active <= 1'b1;
      end
      clk_div_count       <= clk_div_wrap ? '0 : clk_div_count + CLK_DIV_W'(1);
      clock_output_pin_oe <= cfg.clock_output_enable;
      if (!cfg.clock_output_enable) begin
        clock_output_pin <= 1'b0;
      end else if (clk_div_wrap) begin
        clock_output_pin <= !clock_output_pin;
      end
    end
  end

  // Memory, stack and write strobe controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      split_write_strobes         <= 1'b0;
      byte_high_enable_pin_enable <= 1'b1;
      flash_area_external         <= 1'b1;
      save_code_segment           <= 1'b1;
      internal_memory_segment     <= 8'h00;
      stack_size_words            <= 11'h020;
    end else begin
      split_write_strobes         <= cfg.write_strobe_config;
      byte_high_enable_pin_enable <= !cfg.byte_high_disable;
      flash_area_external         <= !cfg.internal_memory_enable;
      save_code_segment           <= !cfg.segmentation_disable;
      internal_memory_segment     <= {7'h00, cfg.internal_memory_segment_select};
      stack_size_words            <= stack_words(cfg.stack_size_select);
    end
  end

  osc_watchdog u_osc_watchdog (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .crystal_input (crystal_input),
    .watch_enable  (osc_watch),
    .osc_fail      (osc_fail)
  );

  chip_select_stage #(
    .WIDTH (CS_WIDTH)
  ) u_chip_select_stage (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .address_latch_enable (address_latch_enable),
    .cs_next              (chip_select_next),
    .unlatched_mode       (cfg.chip_select_timing_config),
    .chip_select_outputs  (chip_select_outputs)
  );

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_write_apply: assert property (cfg_write && !strap_pending
    |=> cfg == $past(pwdata[15:0]) ##1 save_code_segment == !cfg.segmentation_disable)
    else $error("written value not held or not applied");
  chk_read_back: assert property (setup_phase && !pwrite && hit_cfg
    |=> prdata[15:0] == $past(cfg) && prdata[31:16] == 16'h0000)
    else $error("read data does not match register");
  chk_share_block: assert property (##1 xbus_external_block == $past(!cfg.peripheral_share_mode)
    && xram_hold_access == $past(cfg.peripheral_share_mode && hold_mode))
    else $error("peripheral share gating wrong");
  chk_visible_enable: assert property (xbus_visible |-> xbus_enable
    && $past(cfg.visible_mode))
    else $error("visible mode without enable");
  chk_periph_enable: assert property ($rose(cfg.internal_peripheral_enable) |=> xbus_enable)
    else $error("peripheral enable not followed");
  chk_reset_drive: assert property (reset_input_pin_oe |-> !reset_input_pin_out
    && $past(cfg.bidir_reset_pin_enable && internal_reset_active))
    else $error("reset pin driven without cause");
  chk_osc_switch: assert property (osc_watch && osc_fail |=> cpu_clock_from_pll)
    else $error("clock not switched after crystal loss");
  chk_pll_off: assert property (cfg.osc_watchdog_disable && pll_bypassed
    |=> pll_power_off && !cpu_clock_from_pll)
    else $error("pll not off while watchdog disabled");
  chk_pd_nmi: assert property ($rose(powerdown_active) && !$past(cfg.powerdown_config)
    |-> $past(powerdown_instruction && !nmi_sync[1]))
    else $error("power-down entered without low nmi");
  chk_pd_fast_exit: assert property (powerdown_active && cfg.powerdown_config && (|fast_active)
    |=> !powerdown_active)
    else $error("power-down not left on fast interrupt");
  chk_strap_load: assert property (strap_pending && strap_count == STRAP_LOAD_COUNT
    |=> cfg.write_strobe_config == !$past(strap_sync[1].latched_write_config)
    && (cfg & ~STRAP_MASK) == $past(cfg & ~STRAP_MASK))
    else $error("strapped reset fields wrong");
  chk_stack_size: assert property (##1 stack_size_words == $past(stack_words(cfg.stack_size_select))
    && stack_size_words >= 11'h020 && stack_size_words <= 11'h400)
    else $error("stack size decode wrong");
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench of the system configuration register
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sysconf_pkg::*;
  localparam logic [19:0] CFG  = 20'h3fc48;
  localparam logic [19:0] STAT = 20'h3fc4c;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, hold_mode;
  logic internal_reset_active, reset_input_pin_in, reset_input_pin_out, reset_input_pin_oe;
  logic crystal_input, pll_bypassed, powerdown_instruction, nmi_pin, address_latch_enable;
  logic xbus_external_block, xram_hold_access, xbus_visible, xbus_enable, cpu_clock_from_pll;
  logic pll_power_off, powerdown_active, split_write_strobes, clock_output_pin;
  logic clock_output_pin_oe, byte_high_enable_pin_enable, flash_area_external;
  logic save_code_segment, xtal_run, er, last_pin;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0]  fast_external_interrupt_pin, fast_interrupt_enable, internal_memory_segment;
  logic [4:0]  chip_select_next, chip_select_outputs;
  logic [3:0]  clock_output_divider;
  logic [10:0] stack_size_words;
  reset_strap_type reset_straps;
  int failures, compares, toggles;

  system_config_register DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .reset_straps(reset_straps), .hold_mode(hold_mode),
    .internal_reset_active(internal_reset_active), .reset_input_pin_in(reset_input_pin_in),
    .reset_input_pin_out(reset_input_pin_out), .reset_input_pin_oe(reset_input_pin_oe),
    .crystal_input(crystal_input), .pll_bypassed(pll_bypassed),
    .powerdown_instruction(powerdown_instruction), .nmi_pin(nmi_pin),
    .fast_external_interrupt_pin(fast_external_interrupt_pin),
    .fast_interrupt_enable(fast_interrupt_enable), .address_latch_enable(address_latch_enable),
    .chip_select_next(chip_select_next), .clock_output_divider(clock_output_divider),
    .chip_select_outputs(chip_select_outputs), .xbus_external_block(xbus_external_block),
    .xram_hold_access(xram_hold_access), .xbus_visible(xbus_visible),
    .xbus_enable(xbus_enable), .cpu_clock_from_pll(cpu_clock_from_pll),
    .pll_power_off(pll_power_off), .powerdown_active(powerdown_active),
    .split_write_strobes(split_write_strobes), .clock_output_pin(clock_output_pin),
    .clock_output_pin_oe(clock_output_pin_oe),
    .byte_high_enable_pin_enable(byte_high_enable_pin_enable),
    .flash_area_external(flash_area_external), .save_code_segment(save_code_segment),
    .internal_memory_segment(internal_memory_segment), .stack_size_words(stack_size_words));

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (xtal_run) crystal_input <= ~crystal_input;

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [19:0] a, input logic [15:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    er  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w(input logic [15:0] d);
    apb(1'b1, CFG, d);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic rchk(input logic [19:0] a, input logic [15:0] e, input logic ee);
    apb(1'b0, a, 16'h0);
    chk("prdata", {16'h0, e}, rdv);
    chk("pslverr", ee, er);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic pd_pulse(input logic e);
    @(posedge core_clk) powerdown_instruction <= 1'b1;
    @(posedge core_clk) powerdown_instruction <= 1'b0;
    cyc(3);
    chk("powerdown_active", e, powerdown_active);
  endtask

  // Old value must stand until the last cycle before the change
  task automatic cs_try(input logic [4:0] v, input logic [4:0] old, input int n_old,
                        input int n_new);
    @(posedge core_clk);
    chip_select_next     <= v;
    address_latch_enable <= 1'b1;
    cyc(n_old);
    chk("cs_old", {27'h0, old}, chip_select_outputs);
    cyc(n_new - n_old);
    chk("cs_new", {27'h0, v}, chip_select_outputs);
    address_latch_enable <= 1'b0;
    chip_select_next     <= ~v;
    cyc(3);
  endtask

  initial begin
    #200us;
    chk("watchdog", 0, 1);
    report_and_stop();
  end

  initial begin
    core_clk = 1'h0;
    rst_n = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 20'h00000;
    pwdata = 32'h0000_0000;
    reset_straps = 3'h2;
    hold_mode = 1'h1;
    internal_reset_active = 1'h0;
    reset_input_pin_in = 1'h1;
    crystal_input = 1'h0;
    xtal_run = 1'h0;
    pll_bypassed = 1'h0;
    powerdown_instruction = 1'h0;
    nmi_pin = 1'h1;
    fast_external_interrupt_pin = 8'h00;
    fast_interrupt_enable = 8'h01;
    address_latch_enable = 1'h0;
    chip_select_next = 5'h0a;
    clock_output_divider = 4'h1;
    failures = 0;
    compares = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(6);
    rchk(CFG, 16'h0280, 1'b0);
    chk("split", 1, split_write_strobes);
    chk("bhe_en", 0, byte_high_enable_pin_enable);
    chk("flash_ext", 1, flash_area_external);
    w(16'h0001);
    chk("xblock", 0, xbus_external_block);
    chk("xhold", 1, xram_hold_access);
    hold_mode <= 1'b0;
    cyc(2);
    chk("xhold", 0, xram_hold_access);
    hold_mode <= 1'b1;
    w(16'h0006);
    chk("visible", 1, xbus_visible);
    chk("enable", 1, xbus_enable);
    w(16'h0004);
    chk("visible", 0, xbus_visible);
    w(16'h0000);
    chk("xblock", 1, xbus_external_block);
    chk("enable", 0, xbus_enable);
    w(16'h1400);
    chk("segment", 1, internal_memory_segment);
    chk("save_cs", 1, save_code_segment);
    chk("flash_ext", 0, flash_area_external);
    w(16'h0800);
    chk("segment", 0, internal_memory_segment);
    chk("save_cs", 0, save_code_segment);
    for (int c = 0; c < 8; c++) begin
      w({c[2:0], 13'h0});
      chk("stack", 11'h020 << ((c > 5) ? 5 : c), stack_size_words);
    end
    w(16'hffff);
    rchk(CFG, 16'hffff, 1'b0);
    rchk(20'h00100, 16'h0000, 1'b1);
    apb(1'b1, STAT, 16'h0000);
    chk("pslverr", 1, er);
    rchk(CFG, 16'hffff, 1'b0);
    internal_reset_active <= 1'b1;
    w(16'h0008);
    chk("rst_oe", 1, reset_input_pin_oe);
    chk("rst_out", 0, reset_input_pin_out);
    w(16'h0000);
    chk("rst_oe", 0, reset_input_pin_oe);
    internal_reset_active <= 1'b0;
    xtal_run     <= 1'b1;
    pll_bypassed <= 1'b1;
    cyc(40);
    chk("from_pll", 0, cpu_clock_from_pll);
    xtal_run <= 1'b0;
    cyc(40);
    chk("from_pll", 1, cpu_clock_from_pll);
    w(16'h0010);
    chk("from_pll", 0, cpu_clock_from_pll);
    chk("pll_off", 1, pll_power_off);
    pll_bypassed <= 1'b0;
    w(16'h0000);
    chk("pll_off", 0, pll_power_off);
    pd_pulse(1'b0);
    nmi_pin <= 1'b0;
    cyc(3);
    pd_pulse(1'b1);
    rchk(STAT, 16'h000d, 1'b0);
    nmi_pin <= 1'b1;
    reset_input_pin_in <= 1'b0;
    cyc(5);
    chk("pd_exit", 0, powerdown_active);
    reset_input_pin_in <= 1'b1;
    w(16'h0020);
    fast_external_interrupt_pin <= 8'h01;
    cyc(4);
    pd_pulse(1'b0);
    fast_external_interrupt_pin <= 8'h02;
    cyc(4);
    pd_pulse(1'b1);
    fast_external_interrupt_pin <= 8'h01;
    cyc(5);
    chk("pd_exit", 0, powerdown_active);
    fast_external_interrupt_pin <= 8'h00;
    w(16'h0040);
    cyc(3);
    cs_try(5'h15, 5'h00, 1, 2);
    w(16'h0000);
    cs_try(5'h0a, 5'h15, 2, 3);
    w(16'h0100);
    chk("clk_oe", 1, clock_output_pin_oe);
    toggles = 0;
    last_pin = clock_output_pin;
    repeat (16) begin
      cyc(1);
      if (clock_output_pin !== last_pin) toggles++;
      last_pin = clock_output_pin;
    end
    chk("clk_toggles", 8, toggles);
    w(16'h0000);
    chk("clk_pin", 0, clock_output_pin);
    chk("clk_oe", 0, clock_output_pin_oe);
    report_and_stop();
  end
endmodule
`default_nettype wire
